// File: include/irq_regs_pkg.sv
// Shared constants and types for the interrupt flag and priority register slice.
// Assumes one clock domain and a single AHB-Lite master with 32-bit word access.
package irq_regs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_PEND0 = 8'h00;
    localparam logic [7:0] OFF_PRIO5 = 8'h04;
    localparam logic [7:0] OFF_PRIO6 = 8'h08;
    localparam logic [7:0] OFF_PRIO_LOCAL = 8'h0c;
    localparam logic [7:0] OFF_PENDX = 8'h10;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h14;
    localparam logic [7:0] OFF_EVT_MASK = 8'h18;
    localparam logic [7:0] OFF_REQ_STATE = 8'h1c;

    // Field positions
    localparam int PEND0_EXT0_BIT = 0;
    localparam int PEND0_CAP1_BIT = 1;
    localparam int PEND0_CMP1_BIT = 2;
    localparam int PENDX_EXT1_BIT = 0;
    localparam int PENDX_T4_BIT = 1;
    localparam int PRIO5_EXT1_LSB = 0;
    localparam int PRIO6_T4_LSB = 12;
    localparam int LOCAL_EXT0_LSB = 0;
    localparam int LOCAL_CAP1_LSB = 4;
    localparam int LOCAL_CMP1_LSB = 8;
    localparam int REQ_VALID_BIT = 8;
    localparam int REQ_SRC_LSB = 4;

    // Widths and reset values
    localparam int NUM_SRC = 5;
    localparam int LVL_W = 3;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_DISABLED = 3'h0;
    localparam logic [4:0] MASK_RESET = 5'h00;

    // Source numbering, also the pending-vector index
    typedef enum logic [2:0] {
        SRC_EXT0 = 3'b000,
        SRC_CAP1 = 3'b001,
        SRC_CMP1 = 3'b010,
        SRC_EXT1 = 3'b011,
        SRC_T4 = 3'b100
    } irq_src_t;

    // One-cycle event pulses from the peripherals, bit order as irq_src_t
    typedef struct packed {
        logic timer4;
        logic ext1;
        logic compare1;
        logic capture1;
        logic ext0;
    } irq_events_t;

    // Request presented to the core
    typedef struct packed {
        logic valid;
        irq_src_t source;
        logic [2:0] level;
    } irq_req_t;

    // Captured AHB address phase
    typedef struct packed {
        logic write;
        logic [7:0] offset;
    } ahb_phase_t;

    // Extract a 3-bit priority field
    function automatic logic [2:0] prio_field(input logic [15:0] r, input int lsb);
        return r[lsb +: 3];
    endfunction

endpackage

// File: rtl/irq_prio_select.sv
// Picks the highest-priority pending source and registers the result.
// Assumes pending flags and levels come from logic on the same clock.
`timescale 1ns/10ps
module irq_prio_select import irq_regs_pkg::*; #(
    parameter int N_SRC = NUM_SRC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Candidates
    input wire logic [N_SRC-1:0] pend,
    input wire logic [N_SRC*LVL_W-1:0] levels,
    // Winner
    output irq_req_t req_r
);

    irq_req_t req_nxt;
    logic [LVL_W-1:0] lvl;

    // Strict compare, so the lowest source number wins a tie
    always_comb begin
        req_nxt = '{valid: 1'b0, source: SRC_EXT0, level: PRIO_DISABLED};
        lvl = PRIO_DISABLED;
        for (int i = 0; i < N_SRC; i++) begin
            lvl = levels[i*LVL_W +: LVL_W];
            if (pend[i] && lvl != PRIO_DISABLED && lvl > req_nxt.level) begin
                req_nxt.valid = 1'b1;
                req_nxt.source = irq_src_t'(3'(i));
                req_nxt.level = lvl;
            end
        end
    end

    // Registered so the core sees a clean request
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_r <= '{valid: 1'b0, source: SRC_EXT0, level: PRIO_DISABLED};
        end else begin
            req_r <= req_nxt;
        end
    end

endmodule

// File: rtl/irq_flag_priority_regs.sv
// Interrupt pending flags, priority fields and request selection behind an AHB-Lite slave.
// Assumes event pulses and bus signals are synchronous to ref_clk; word accesses only.
//
// How it works
// - compare channel 1 flag at bit 2
// - capture channel 1 flag at bit 1
// - external interrupt 0 flag at bit 0
// - priority code 111 means level 7, highest
// - code 001 is level 1, linear between
// - code 000 disables the source entirely; here only core_req ignores it, irq_out still follows evt_mask_r
// - ext irq1 priority bits 2:0, resets 100
// - timer4 priority bits 14:12, resets 100, optional
// - unimplemented bits ignore writes, read zero
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module irq_flag_priority_regs import irq_regs_pkg::*; #(
    parameter bit HAS_TIMER4 = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Peripheral events
    input wire irq_events_t event_in,
    // Core side
    output irq_req_t core_req,
    output logic irq_out
);

    // Register state
    logic [2:0] pend0_r;
    logic [1:0] pendx_r;
    logic [2:0] ext1_prio_r;
    logic [2:0] t4_prio_r;
    logic [2:0] ext0_prio_r;
    logic [2:0] cap1_prio_r;
    logic [2:0] cmp1_prio_r;
    logic [NUM_SRC-1:0] evt_status_r;
    logic [NUM_SRC-1:0] evt_mask_r;
    logic [31:0] hrdata_r;
    ahb_phase_t phase_r;
    logic wr_pend_r;

    // Decode helpers
    logic addr_ok;
    logic accept;
    logic rd_accept;
    logic wr_now;
    logic [7:0] wr_off;
    logic [15:0] wdata16;
    logic [15:0] prio5_view;
    logic [15:0] prio6_view;
    logic [15:0] local_view;
    logic [NUM_SRC-1:0] pend_vec;
    logic [NUM_SRC*LVL_W-1:0] lvl_vec;
    logic t4_event;

    // True when the offset lands on a mapped word
    function automatic logic reg_hit(input logic [31:0] a);
        logic hit;
        hit = 1'b0;
        if (a[31:8] == 24'h000000 && a[1:0] == 2'b00) begin
            case (a[7:0])
                OFF_PEND0, OFF_PRIO5, OFF_PRIO6, OFF_PRIO_LOCAL,
                OFF_PENDX, OFF_EVT_STATUS, OFF_EVT_MASK, OFF_REQ_STATE: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    // Zero-wait slave; every transfer gets OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Address phase qualification
    assign addr_ok = reg_hit(haddr);
    assign accept = hsel && htrans[1] && hready;
    assign rd_accept = accept && !hwrite;
    assign wr_now = wr_pend_r && phase_r.write;
    assign wr_off = phase_r.offset;
    assign wdata16 = hwdata[15:0];

    // Absent timer4 variant sees no events from it
    assign t4_event = HAS_TIMER4 && event_in.timer4;

    // Register views; unused bits are constant zero
    always_comb begin
        prio5_view = 16'h0000;
        prio6_view = 16'h0000;
        local_view = 16'h0000;
        prio5_view[PRIO5_EXT1_LSB +: 3] = ext1_prio_r;
        prio6_view[PRIO6_T4_LSB +: 3] = t4_prio_r;
        local_view[LOCAL_EXT0_LSB +: 3] = ext0_prio_r;
        local_view[LOCAL_CAP1_LSB +: 3] = cap1_prio_r;
        local_view[LOCAL_CMP1_LSB +: 3] = cmp1_prio_r;
    end

    // Capture the address phase; writes commit in the data phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            phase_r <= '{write: 1'b0, offset: 8'h00};
        end else begin
            wr_pend_r <= accept && hwrite && addr_ok;
            if (accept) begin
                phase_r <= '{write: hwrite, offset: haddr[7:0]};
            end
        end
    end

    // Read data is latched at the address phase so it stands in the data phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_accept) begin
            hrdata_r <= 32'h00000000;
            if (addr_ok) begin
                case (haddr[7:0])
                    OFF_PEND0: hrdata_r[2:0] <= pend0_r;
                    OFF_PRIO5: hrdata_r[15:0] <= prio5_view;
                    OFF_PRIO6: hrdata_r[15:0] <= prio6_view;
                    OFF_PRIO_LOCAL: hrdata_r[15:0] <= local_view;
                    OFF_PENDX: hrdata_r[1:0] <= pendx_r;
                    OFF_EVT_STATUS: hrdata_r[NUM_SRC-1:0] <= evt_status_r;
                    OFF_EVT_MASK: hrdata_r[NUM_SRC-1:0] <= evt_mask_r;
                    OFF_REQ_STATE: begin
                        hrdata_r[REQ_VALID_BIT] <= core_req.valid;
                        hrdata_r[REQ_SRC_LSB +: 3] <= core_req.source;
                        hrdata_r[2:0] <= core_req.level;
                    end
                    default: hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // First flag register; an event in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pend0_r <= 3'h0;
        end else begin
            if (wr_now && wr_off == OFF_PEND0) begin
                pend0_r <= wdata16[2:0];
            end
            if (event_in.ext0) begin
                pend0_r[PEND0_EXT0_BIT] <= 1'b1;
            end
            if (event_in.capture1) begin
                pend0_r[PEND0_CAP1_BIT] <= 1'b1;
            end
            if (event_in.compare1) begin
                pend0_r[PEND0_CMP1_BIT] <= 1'b1;
            end
        end
    end

    // Pending flags of the two sources whose flags live elsewhere
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pendx_r <= 2'h0;
        end else begin
            if (wr_now && wr_off == OFF_PENDX) begin
                pendx_r[PENDX_EXT1_BIT] <= wdata16[PENDX_EXT1_BIT];
                pendx_r[PENDX_T4_BIT] <= HAS_TIMER4 && wdata16[PENDX_T4_BIT];
            end
            if (event_in.ext1) begin
                pendx_r[PENDX_EXT1_BIT] <= 1'b1;
            end
            if (t4_event) begin
                pendx_r[PENDX_T4_BIT] <= 1'b1;
            end
        end
    end

    // External interrupt 1 priority
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ext1_prio_r <= PRIO_RESET;
        end else if (wr_now && wr_off == OFF_PRIO5) begin
            ext1_prio_r <= prio_field(wdata16, PRIO5_EXT1_LSB);
        end
    end

    // Timer4 priority; held at zero when the variant lacks the timer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            t4_prio_r <= HAS_TIMER4 ? PRIO_RESET : PRIO_DISABLED;
        end else if (HAS_TIMER4 && wr_now && wr_off == OFF_PRIO6) begin
            t4_prio_r <= prio_field(wdata16, PRIO6_T4_LSB);
        end
    end

    // Priorities of the three flagged sources
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ext0_prio_r <= PRIO_RESET;
            cap1_prio_r <= PRIO_RESET;
            cmp1_prio_r <= PRIO_RESET;
        end else if (wr_now && wr_off == OFF_PRIO_LOCAL) begin
            ext0_prio_r <= prio_field(wdata16, LOCAL_EXT0_LSB);
            cap1_prio_r <= prio_field(wdata16, LOCAL_CAP1_LSB);
            cmp1_prio_r <= prio_field(wdata16, LOCAL_CMP1_LSB);
        end
    end

    // Sticky event status, cleared by reading it; a new event beats the clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evt_status_r <= '0;
        end else begin
            if (rd_accept && haddr == {24'h000000, OFF_EVT_STATUS}) begin
                evt_status_r <= {t4_event, event_in.ext1, event_in.compare1,
                                 event_in.capture1, event_in.ext0};
            end else begin
                evt_status_r <= evt_status_r | {t4_event, event_in.ext1, event_in.compare1,
                                                 event_in.capture1, event_in.ext0};
            end
        end
    end

    // Interrupt mask, same layout as the status
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            evt_mask_r <= MASK_RESET;
        end else if (wr_now && wr_off == OFF_EVT_MASK) begin
            evt_mask_r <= wdata16[NUM_SRC-1:0];
        end
    end

    // Level interrupt while any unmasked status bit is set
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(evt_status_r & evt_mask_r);
        end
    end

    // Candidate vectors in source order
    assign pend_vec = {pendx_r[PENDX_T4_BIT], pendx_r[PENDX_EXT1_BIT],
                       pend0_r[PEND0_CMP1_BIT], pend0_r[PEND0_CAP1_BIT], pend0_r[PEND0_EXT0_BIT]};
    assign lvl_vec = {t4_prio_r, ext1_prio_r, cmp1_prio_r, cap1_prio_r, ext0_prio_r};

    // Priority selection, one cycle after flags or levels change
    irq_prio_select #(
        .N_SRC(NUM_SRC)
    ) u_select (
        .ref_clk(ref_clk),
        .reset(reset),
        .pend(pend_vec),
        .levels(lvl_vec),
        .req_r(core_req)
    );

endmodule

// File: verif/irq_regs_monitor.sv
// Assertions on the flag and priority slice ports.
// Assumes bind onto irq_flag_priority_regs, one clock domain.
`timescale 1ns/10ps
module irq_regs_monitor import irq_regs_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Events and request
    input wire irq_events_t event_in,
    input wire irq_req_t core_req
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Request-state word as the register map lays it out
    function automatic logic [31:0] req_word(input irq_req_t q);
        req_word = '0;
        req_word[REQ_VALID_BIT] = q.valid;
        req_word[REQ_SRC_LSB +: 3] = q.source;
        req_word[2:0] = q.level;
    endfunction
    // Accepted read address phase at one offset
    sequence rd_at(logic [7:0] off);
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == off;
    endsequence
    // No event and no accepted write; writes land a cycle late
    sequence quiet;
        event_in == '0 && !(hsel && htrans[1] && hready && hwrite);
    endsequence
    chk_evt_req: assert property (|event_in[2:0] |-> ##2 core_req.valid)
        else $error("no request two cycles after event");
    chk_level_nonzero: assert property (core_req.valid |-> core_req.level != PRIO_DISABLED)
        else $error("disabled level presented");
    chk_src_legal: assert property (core_req.valid |-> core_req.source <= SRC_T4)
        else $error("request source out of range");
    chk_req_hold: assert property (quiet [*3] |=> $stable(core_req))
        else $error("request moved without cause");
    chk_pend0_unused: assert property (rd_at(OFF_PEND0) |=> hrdata[31:3] == '0)
        else $error("pending flags upper bits set");
    chk_prio5_unused: assert property (rd_at(OFF_PRIO5) |=> hrdata[31:3] == '0)
        else $error("priority 5 unused bits set");
    chk_prio6_unused: assert property (rd_at(OFF_PRIO6) |=> hrdata[31:15] == '0 && hrdata[11:0] == '0)
        else $error("priority 6 unused bits set");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    chk_req_readback: assert property (rd_at(OFF_REQ_STATE) |=> hrdata == req_word($past(core_req)))
        else $error("request state readback wrong");
endmodule

bind irq_flag_priority_regs irq_regs_monitor u_mon (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .event_in, .core_req);

// File: verif/irq_event_src.sv
// Peripheral event sources: each command becomes a one-cycle pulse.
// Assumes the bench raises fire for a single cycle.
`timescale 1ns/10ps
module irq_event_src import irq_regs_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Command and pulses
    input wire irq_events_t fire,
    output irq_events_t event_out
);
    // Registered, so pulses leave just after an edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            event_out <= '0;
        end else begin
            event_out <= fire;
        end
    end
endmodule

// File: verif/irq_flag_priority_regs_bench.sv
// Self-checking bench for the flag and priority slice.
// Assumes the monitor is bound in its own file; AHB-Lite master lives in tasks.
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module irq_flag_priority_regs_bench import irq_regs_pkg::*;;
    logic ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, irq_out;
    irq_events_t fire = '0, event_in;
    irq_req_t core_req;
    int err_count = 0, num_checks = 0, cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    irq_flag_priority_regs u_dut (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .event_in, .core_req, .irq_out);
    irq_event_src u_src (.ref_clk, .reset, .fire, .event_out(event_in));

    // Single transfer; waits on ready, no fixed latency assumed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    // Settle point away from the sampling edge
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic pulse(input irq_events_t v);
        @(posedge ref_clk);
        fire <= v;
        @(posedge ref_clk);
        fire <= '0;
        idle(4);
    endtask

    task automatic t_reset;
        xfer(0, OFF_PRIO5, 0);
        `CHK("prio5 reset", 32'(PRIO_RESET), rd)
        xfer(0, OFF_PRIO6, 0);
        `CHK("prio6 reset", 32'(PRIO_RESET) << PRIO6_T4_LSB, rd)
        xfer(0, OFF_PEND0, 0);
        `CHK("pend0 reset", 32'h0, rd)
        xfer(0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        xfer(1, OFF_PRIO5, 32'hffff_ffff);
        xfer(0, OFF_PRIO5, 0);
        `CHK("prio5 ones", 32'h7, rd)
        xfer(1, OFF_PRIO6, 32'hffff_ffff);
        xfer(0, OFF_PRIO6, 0);
        `CHK("prio6 ones", 32'h7000, rd)
        $display("test reset and unused bits done");
    endtask

    task automatic t_flags;
        for (int i = 0; i < 3; i++) begin
            pulse(irq_events_t'(5'h1 << i));
            xfer(0, OFF_PEND0, 0);
            `CHK("pend0 flag", 32'h1 << i, rd)
            `CHK("winner", {1'b1, irq_src_t'(i), PRIO_RESET}, core_req)
            xfer(1, OFF_PEND0, 0);
            idle(2);
            `CHK("flag cleared", 1'b0, core_req.valid)
        end
        $display("test flags done");
    endtask

    // Ext1 swept against ext0 at level 4; ties go to ext0
    task automatic t_prio;
        for (int c = 0; c < 8; c++) begin
            xfer(1, OFF_PRIO5, c);
            pulse(irq_events_t'(5'h09));
            `CHK("ext1 vs ext0", (c > 4) ? {1'b1, SRC_EXT1, 3'(c)} : {1'b1, SRC_EXT0, PRIO_RESET}, core_req)
            xfer(1, OFF_PEND0, 0);
            xfer(1, OFF_PENDX, 0);
        end
        xfer(1, OFF_PRIO6, 0);
        pulse(irq_events_t'(5'h10));
        `CHK("t4 disabled", 1'b0, core_req.valid)
        xfer(1, OFF_PRIO6, 32'h7000);
        idle(2);
        `CHK("t4 level7", {1'b1, SRC_T4, 3'h7}, core_req)
        xfer(0, OFF_REQ_STATE, 0);
        `CHK("req state", (32'h1 << REQ_VALID_BIT) | (32'(SRC_T4) << REQ_SRC_LSB) | 32'h7, rd)
        xfer(1, OFF_PENDX, 0);
        // Local levels: ext0 3, capture1 2, compare1 1; spare bits written high
        xfer(0, OFF_PRIO_LOCAL, 0);
        `CHK("local reset", 32'h444, rd)
        xfer(1, OFF_PRIO_LOCAL, 32'hffff_f9ab);
        xfer(0, OFF_PRIO_LOCAL, 0);
        `CHK("local levels", 32'h123, rd)
        pulse(irq_events_t'(5'h06));
        `CHK("cap1 over cmp1", {1'b1, SRC_CAP1, 3'h2}, core_req)
        xfer(1, OFF_PEND0, 0);
        $display("test priority done");
    endtask

    task automatic t_irq;
        xfer(0, OFF_EVT_STATUS, 0);
        xfer(1, OFF_EVT_MASK, 32'h1);
        pulse(irq_events_t'(5'h03));
        `CHK("irq raised", 1'b1, irq_out)
        xfer(0, OFF_EVT_STATUS, 0);
        `CHK("status", 32'h3, rd)
        idle(2);
        `CHK("irq cleared", 1'b0, irq_out)
        pulse(irq_events_t'(5'h02));
        `CHK("irq masked", 1'b0, irq_out)
        xfer(1, OFF_PEND0, 0);
        $display("test interrupt done");
    endtask

    // Reset in mid-run returns flags, levels and outputs to reset values
    task automatic t_midreset;
        xfer(1, OFF_EVT_MASK, 32'h1);
        pulse(irq_events_t'(5'h01));
        `CHK("irq before reset", 1'b1, irq_out)
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        idle(0);
        `CHK("req after reset", 7'h00, core_req)
        `CHK("irq after reset", 1'b0, irq_out)
        xfer(0, OFF_PEND0, 0);
        `CHK("pend0 after reset", 32'h0, rd)
        xfer(0, OFF_PRIO5, 0);
        `CHK("prio5 after reset", 32'(PRIO_RESET), rd)
        $display("test mid-run reset done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_flags();
        t_prio();
        t_irq();
        t_midreset();
        wrap_up();
    end
endmodule
